// >>> verilog/cpob_pkg.sv
// package with object indices, field layouts, reset values and carrier structs for the profile object bank
package cpob_pkg;

  // object dictionary indices
  localparam logic [15:0] CPOB_IDX_PROFILE  = 16'h1000;
  localparam logic [15:0] CPOB_IDX_SUMMARY  = 16'h1001;
  localparam logic [15:0] CPOB_IDX_HISTORY  = 16'h1003;
  localparam logic [15:0] CPOB_IDX_SYNC_ID  = 16'h1005;
  localparam logic [15:0] CPOB_IDX_SYNC_PER = 16'h1006;
  localparam logic [15:0] CPOB_IDX_NAME     = 16'h1008;
  localparam logic [7:0]  CPOB_SUB_ZERO     = 8'h00;

  // device profile word layout
  localparam logic [15:0] CPOB_PROFILE_NUM  = {8'h01, 8'h91};
  localparam int          CPOB_MOD_LSB      = 17;

  // fault summary bit positions
  localparam int          CPOB_FS_GENERAL   = 0;
  localparam int          CPOB_FS_COMM      = 4;
  localparam int          CPOB_FS_RSVD      = 6;

  // history entry layout and communication fault code logged on sync loss
  localparam int          CPOB_ENT_ADD_LSB  = 16;
  localparam logic [15:0] CPOB_SYNC_ERR     = 16'h8100;
  localparam int          CPOB_HIST_DEPTH   = 20;

  // sync identifier and period
  localparam int          CPOB_ID_BITS      = 11;
  localparam logic [31:0] CPOB_SYNC_ID_RST  = 32'h0000_0080;
  localparam logic [31:0] CPOB_SYNC_PER_RST = 32'h0000_0000;

  // sync supervision granularity: 2 ms steps at a 100 ns clock
  localparam int          CPOB_RES_US       = 2000;
  localparam int          CPOB_CLK_NS       = 100;
  localparam int          CPOB_TICK_CYCLES  = (CPOB_RES_US * 1000) / CPOB_CLK_NS;
  localparam logic [31:0] CPOB_RES_STEP     = 32'(CPOB_RES_US);
  localparam logic [31:0] CPOB_US_MAX       = 32'hffff_ffff;

  // device name text, four ascii characters; value is arbitrary
  localparam logic [31:0] CPOB_NAME_RST     = 32'h494f_4350;

  // master access to the object dictionary
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } cpob_req_s;

  // answer to a master access
  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } cpob_rsp_s;

  // fault reported by the device logic
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [15:0] add;
  } cpob_fault_s;

  // emergency message contents
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [15:0] add;
    logic [7:0]  summary;
  } cpob_emcy_s;

endpackage

// >>> verilog/cpob_bank.sv
// communication profile object bank: device type, fault summary, history, sync id, sync period, name
//
// Overview of operation
// - module-present flags set profile word bits
// - lower half holds profile number 0x0191
// - summary byte bit per fault category
// - emergency message carries current summary byte
// - any category fault other than reserved bit 6, or sync loss, sets the general bit
// - new fault enters position one, others shift
// - at most twenty entries, count reports stored
// - full history drops the entry at position twenty
// - entry: additional code high, error code low
// - writing zero to count clears history
// - sync id eleven bits, upper bits zero
// - sync period checked in 2 ms steps
// - zero period disables sync supervision
// - read-only device name text object
`timescale 1ns/10ps

module cpob_bank #(
  parameter int TICK_CYCLES = cpob_pkg::CPOB_TICK_CYCLES, // clock cycles per 2 ms step
  parameter int HIST_DEPTH  = cpob_pkg::CPOB_HIST_DEPTH   // fault history entries
) (
  input  wire logic                  clock,        // 10 MHz clock
  input  wire logic                  resetn,       // async reset, active low
  input  wire cpob_pkg::cpob_req_s   od_req,       // master access
  output cpob_pkg::cpob_rsp_s        od_rsp,       // answer, one cycle later
  input  wire logic [3:0]            mod_present,  // di, do, ai, ao attached
  input  wire logic [7:1]            fault_cat,    // active fault categories
  input  wire cpob_pkg::cpob_fault_s fault_evt,    // new fault to log
  input  wire logic                  sync_rx,      // sync message received
  output cpob_pkg::cpob_emcy_s       emcy,         // emergency to transmit
  output logic [7:0]                 fault_sum,    // current fault summary
  output logic [10:0]                sync_id       // active sync identifier
);
  import cpob_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int CW = $clog2(HIST_DEPTH + 1);

  // refuse sizes the count field or the tick counter cannot serve
  if (HIST_DEPTH < 1 || HIST_DEPTH > 254) begin : g_bad_depth
    $error("cpob_bank: HIST_DEPTH out of range");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("cpob_bank: TICK_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [HIST_DEPTH-1:0][31:0] hist;      // position 1 is element 0
    logic [CW-1:0]               count;
    logic [31:0]                 sync_id;
    logic [31:0]                 sync_per;
    logic [TW-1:0]               tick;
    logic [31:0]                 elapsed;   // microseconds since last sync
    logic                        sync_lost; // sticky until next sync or period write
    logic                        log_pend;  // sync loss waiting for a history slot
    logic [31:0]                 profile;
    logic [7:0]                  summary;
    cpob_rsp_s                   rsp;
    cpob_emcy_s                  emcy;
  } cpob_state_s;

  cpob_state_s state_q;
  cpob_state_s state_d;

  // true when the index names an object that accepts no writes
  function automatic logic cpob_ro(input logic [15:0] idx);
    cpob_ro = (idx == CPOB_IDX_PROFILE) || (idx == CPOB_IDX_SUMMARY) || (idx == CPOB_IDX_NAME);
  endfunction

  // summary byte built from the category inputs and the sync loss flag
  function automatic logic [7:0] cpob_sum(input logic [7:1] cat, input logic lost);
    logic [7:0] s;
    s = {cat, 1'b0};
    s[CPOB_FS_COMM] = s[CPOB_FS_COMM] | lost;
    s[CPOB_FS_RSVD] = 1'b0;
    s[CPOB_FS_GENERAL] = |s;
    cpob_sum = s;
  endfunction

  logic [7:0]  sum_now;
  logic        timeout;
  logic        do_log;
  logic [31:0] log_entry;
  logic        clear_hist;
  logic [7:0]  hsub;

  always_comb begin
    state_d = state_q;
    hsub = od_req.subindex;

    // sync supervision: accumulate 2 ms steps, compare against the period in microseconds
    timeout = 1'b0;
    if (sync_rx || state_q.sync_per == CPOB_SYNC_PER_RST) begin
      state_d.tick = '0;
      state_d.elapsed = '0;
      if (sync_rx) state_d.sync_lost = 1'b0;
    end else if (state_q.tick == TW'(TICK_CYCLES - 1)) begin
      state_d.tick = '0;
      if (state_q.elapsed > CPOB_US_MAX - CPOB_RES_STEP) state_d.elapsed = CPOB_US_MAX;
      else state_d.elapsed = state_q.elapsed + CPOB_RES_STEP;
    end else begin
      state_d.tick = state_q.tick + TW'(1);
    end
    // resolution is 2 ms, so a loss is seen up to one step late
    if (!sync_rx && state_q.sync_per != CPOB_SYNC_PER_RST && !state_q.sync_lost
        && state_q.elapsed > state_q.sync_per) begin
      timeout = 1'b1;
      state_d.sync_lost = 1'b1;
      state_d.log_pend = 1'b1;
    end

    sum_now = cpob_sum(fault_cat, state_d.sync_lost);
    state_d.summary = sum_now;
    state_d.profile = {8'h00, 3'b000, mod_present, 1'b0, CPOB_PROFILE_NUM};

    // external fault goes first; a pending sync loss takes the next free cycle
    do_log = fault_evt.valid || state_q.log_pend || timeout;
    if (fault_evt.valid) begin
      log_entry = {fault_evt.add, fault_evt.code};
    end else begin
      log_entry = {16'h0000, CPOB_SYNC_ERR};
      state_d.log_pend = 1'b0;
    end

    // master access: answer registered one cycle later
    clear_hist = 1'b0;
    state_d.rsp = '0;
    state_d.rsp.ack = od_req.valid;
    if (od_req.valid) begin
      unique case (od_req.index)
        CPOB_IDX_PROFILE, CPOB_IDX_SUMMARY, CPOB_IDX_NAME,
        CPOB_IDX_SYNC_ID, CPOB_IDX_SYNC_PER: begin
          if (od_req.subindex != CPOB_SUB_ZERO) begin
            state_d.rsp.abort = 1'b1;
          end else if (od_req.write && cpob_ro(od_req.index)) begin
            state_d.rsp.abort = 1'b1;
          end else if (od_req.write && od_req.index == CPOB_IDX_SYNC_ID) begin
            state_d.sync_id = {21'h0, od_req.wdata[CPOB_ID_BITS-1:0]};
          end else if (od_req.write) begin
            state_d.sync_per = od_req.wdata;
            state_d.tick = '0;
            state_d.elapsed = '0;
            state_d.sync_lost = 1'b0;
          end else begin
            unique case (od_req.index)
              CPOB_IDX_PROFILE: state_d.rsp.rdata = state_q.profile;
              CPOB_IDX_SUMMARY: state_d.rsp.rdata = {24'h0, state_q.summary};
              CPOB_IDX_SYNC_ID: state_d.rsp.rdata = state_q.sync_id;
              CPOB_IDX_SYNC_PER: state_d.rsp.rdata = state_q.sync_per;
              default: state_d.rsp.rdata = CPOB_NAME_RST;
            endcase
          end
        end
        CPOB_IDX_HISTORY: begin
          if (od_req.write) begin
            // only the count is writable, and only with zero
            if (hsub == CPOB_SUB_ZERO && od_req.wdata == 32'h0) clear_hist = 1'b1;
            else state_d.rsp.abort = 1'b1;
          end else if (hsub == CPOB_SUB_ZERO) begin
            state_d.rsp.rdata = 32'(state_q.count);
          end else if (hsub > 8'(HIST_DEPTH)) begin
            state_d.rsp.abort = 1'b1;
          end else begin
            // positions beyond the count read as zero
            state_d.rsp.rdata = state_q.hist[hsub - 8'h01];
          end
        end
        default: state_d.rsp.abort = 1'b1;
      endcase
    end

    // history: clear first, so a fault in the same cycle survives as entry 1
    if (clear_hist) begin
      state_d.hist = '0;
      state_d.count = '0;
    end
    if (do_log) begin
      // newest at position 1; the oldest falls off position 20 when full
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        state_d.hist[i] = state_d.hist[i-1];
      end
      state_d.hist[0] = log_entry;
      if (state_d.count != CW'(HIST_DEPTH)) state_d.count = state_d.count + CW'(1);
    end

    // every logged fault goes out as an emergency with the live summary
    state_d.emcy.valid = do_log;
    state_d.emcy.code = log_entry[CPOB_ENT_ADD_LSB-1:0];
    state_d.emcy.add = log_entry[31:CPOB_ENT_ADD_LSB];
    state_d.emcy.summary = sum_now;
  end

  // single state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
      state_q.sync_id <= CPOB_SYNC_ID_RST;
      state_q.sync_per <= CPOB_SYNC_PER_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign od_rsp = state_q.rsp;
  assign emcy = state_q.emcy;
  assign fault_sum = state_q.summary;
  assign sync_id = state_q.sync_id[CPOB_ID_BITS-1:0];

endmodule

// >>> testbench/cpob_bank_monitor.sv
// port checker for the profile object bank
`timescale 1ns/10ps
module cpob_bank_monitor #(
  parameter int TICK_CYCLES = 10, // clocks per step
  parameter int HIST_DEPTH  = 20  // history depth
) (
  input wire logic                  clock,       // clock
  input wire logic                  resetn,      // reset
  input wire cpob_pkg::cpob_req_s   od_req,      // request
  input wire cpob_pkg::cpob_rsp_s   od_rsp,      // answer
  input wire logic [3:0]            mod_present, // modules
  input wire logic [7:1]            fault_cat,   // categories
  input wire cpob_pkg::cpob_fault_s fault_evt,   // fault
  input wire logic                  sync_rx,     // sync
  input wire cpob_pkg::cpob_emcy_s  emcy,        // emergency
  input wire logic [7:0]            fault_sum,   // summary
  input wire logic [10:0]           sync_id      // sync id
);
  import cpob_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // decoded reads and writes to subindex zero, and history reads of any subindex
  wire rd0 = od_req.valid && !od_req.write && od_req.subindex == CPOB_SUB_ZERO;
  wire wr0 = od_req.valid && od_req.write && od_req.subindex == CPOB_SUB_ZERO;
  wire hr = od_req.valid && !od_req.write && od_req.index == CPOB_IDX_HISTORY;
  a_ro_write: assert property (wr0 && od_req.index == CPOB_IDX_PROFILE |=> od_rsp.ack && od_rsp.abort)
    else $error("profile write not refused");
  a_gen_bit: assert property (fault_sum[0] == |fault_sum[7:1])
    else $error("general bit wrong");
  a_rsvd_low: assert property (!fault_sum[6])
    else $error("reserved bit set");
  a_emcy_code: assert property (fault_evt.valid |=> emcy.valid && {emcy.add, emcy.code} == $past({fault_evt.add, fault_evt.code}))
    else $error("emergency codes wrong");
  a_emcy_sum: assert property (emcy.valid |-> emcy.summary == fault_sum)
    else $error("emergency summary wrong");
  a_prof_flags: assert property (rd0 && od_req.index == CPOB_IDX_PROFILE |=> od_rsp.rdata[20:17] == $past(mod_present, 2))
    else $error("module flags wrong");
  a_prof_num: assert property (rd0 && od_req.index == CPOB_IDX_PROFILE |=> od_rsp.rdata[15:0] == CPOB_PROFILE_NUM)
    else $error("profile number wrong");
  a_id_upper: assert property (rd0 && od_req.index == CPOB_IDX_SYNC_ID |=> od_rsp.rdata == {21'h0, $past(sync_id)})
    else $error("sync id read wrong");
  a_hist_oob: assert property (hr && od_req.subindex == 8'(HIST_DEPTH + 1) |=> od_rsp.abort)
    else $error("read past history");
  // clear then read count back, no fault in between
  a_clear_zero: assert property (wr0 && od_req.index == CPOB_IDX_HISTORY && od_req.wdata == 32'h0 && !fault_evt.valid
    ##1 !fault_evt.valid ##1 hr && rd0 && !fault_evt.valid |=> od_rsp.rdata == 32'h0)
    else $error("count not cleared");
  c_fault: cover property (fault_evt.valid);
  c_lost: cover property (emcy.valid && emcy.code == CPOB_SYNC_ERR);
  c_abort: cover property (od_rsp.abort);
endmodule
bind cpob_bank cpob_bank_monitor #(.TICK_CYCLES(TICK_CYCLES), .HIST_DEPTH(HIST_DEPTH)) i_mon (
  .clock(clock), .resetn(resetn), .od_req(od_req), .od_rsp(od_rsp), .mod_present(mod_present),
  .fault_cat(fault_cat), .fault_evt(fault_evt), .sync_rx(sync_rx), .emcy(emcy), .fault_sum(fault_sum),
  .sync_id(sync_id));

// >>> testbench/cpob_master.sv
// network master model issuing object accesses
`timescale 1ns/10ps
module cpob_master (
  input  wire logic                clock,  // clock
  output cpob_pkg::cpob_req_s      od_req, // request
  input  wire cpob_pkg::cpob_rsp_s od_rsp  // answer
);
  import cpob_pkg::*;
  initial od_req = '0;
  // one access; released fields are inverted so stale values never look valid
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                     output logic [32:0] r);
    @(negedge clock);
    od_req = '{1'b1, w, i, s, d};
    @(negedge clock);
    od_req = '{1'b0, ~w, ~i, ~s, ~d};
    r = (od_rsp.ack === 1'b1) ? {od_rsp.abort, od_rsp.rdata} : 'x;
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the profile object bank
`timescale 1ns/10ps
module tb_top;
  import cpob_pkg::*;
  localparam int TICK = 10;
  logic        clock = 0, resetn = 0, sync_rx = 0;
  logic [3:0]  mod_present = '0;
  logic [7:1]  fault_cat = '0;
  cpob_fault_s fault_evt = '0;
  cpob_req_s   od_req;
  cpob_rsp_s   od_rsp;
  cpob_emcy_s  emcy;
  logic [7:0]  fault_sum;
  logic [10:0] sync_id;
  logic [32:0] r;
  int          n_errors = 0, n_tests = 0;
  cpob_bank #(.TICK_CYCLES(TICK), .HIST_DEPTH(CPOB_HIST_DEPTH)) i_dut (.clock(clock), .resetn(resetn),
    .od_req(od_req), .od_rsp(od_rsp), .mod_present(mod_present), .fault_cat(fault_cat), .fault_evt(fault_evt),
    .sync_rx(sync_rx), .emcy(emcy), .fault_sum(fault_sum), .sync_id(sync_id));
  cpob_master i_mst (.clock(clock), .od_req(od_req), .od_rsp(od_rsp));
  initial forever #50 clock = ~clock;
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // read compares abort flag and data together
  task automatic rd(input string n, input logic [15:0] i, input logic [7:0] s, input logic [32:0] e);
    i_mst.acc(1'b0, i, s, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ab);
    i_mst.acc(1'b1, i, s, d, r);
    chk("write abort", {32'h0, ab}, {32'h0, r[32]});
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_reset;
    rd("sync id", CPOB_IDX_SYNC_ID, 8'h0, {1'b0, CPOB_SYNC_ID_RST});
    rd("period", CPOB_IDX_SYNC_PER, 8'h0, 33'h0);
    rd("count", CPOB_IDX_HISTORY, 8'h0, 33'h0);
    rd("name", CPOB_IDX_NAME, 8'h0, {1'b0, CPOB_NAME_RST});
    rd("unmapped", 16'h1009, 8'h0, {1'b1, 32'h0});
    wr(CPOB_IDX_NAME, 8'h0, 32'h0, 1'b1);
    wr(CPOB_IDX_SUMMARY, 8'h0, 32'hff, 1'b1);
  endtask
  task automatic t_profile;
    for (int i = 0; i < 4; i++) begin
      mod_present = 4'h1 << i;
      repeat (2) @(negedge clock);
      rd("profile", CPOB_IDX_PROFILE, 8'h0, {12'h0, mod_present, 1'b0, CPOB_PROFILE_NUM});
    end
    wr(CPOB_IDX_PROFILE, 8'h0, 32'hffff_ffff, 1'b1);
    rd("profile kept", CPOB_IDX_PROFILE, 8'h0, {12'h0, 4'h8, 1'b0, CPOB_PROFILE_NUM});
  endtask
  task automatic t_summary;
    for (int c = 1; c < 8; c++) begin
      fault_cat = 7'h1 << (c - 1);
      repeat (2) @(negedge clock);
      rd("summary", CPOB_IDX_SUMMARY, 8'h0, (c == 6) ? 33'h0 : (33'h1 << c) | 33'h1);
    end
    fault_cat = '0;
  endtask
  // overfill the history with back-to-back faults, then clear it
  task automatic t_history;
    for (int k = 0; k < 22; k++) begin
      fault_evt = '{1'b1, 16'h1000 + 16'(k), 16'(k)};
      @(negedge clock);
    end
    fault_evt = '0;
    rd("count", CPOB_IDX_HISTORY, 8'h0, 33'd20);
    rd("newest", CPOB_IDX_HISTORY, 8'h1, {17'd21, 16'h1015});
    rd("oldest", CPOB_IDX_HISTORY, 8'd20, {17'd2, 16'h1002});
    rd("past end", CPOB_IDX_HISTORY, 8'd21, {1'b1, 32'h0});
    wr(CPOB_IDX_HISTORY, 8'h0, 32'h5, 1'b1);
    wr(CPOB_IDX_HISTORY, 8'h0, 32'h0, 1'b0);
    rd("cleared", CPOB_IDX_HISTORY, 8'h0, 33'h0);
    rd("entry gone", CPOB_IDX_HISTORY, 8'h1, 33'h0);
  endtask
  task automatic t_sync;
    wr(CPOB_IDX_SYNC_ID, 8'h0, 32'hffff_ffff, 1'b0);
    rd("id masked", CPOB_IDX_SYNC_ID, 8'h0, 33'h7ff);
    chk("sync pin", 33'h7ff, {22'h0, sync_id});
    repeat (60) @(negedge clock);
    rd("unwatched", CPOB_IDX_SUMMARY, 8'h0, 33'h0);
    wr(CPOB_IDX_SYNC_PER, 8'h0, 32'd1000, 1'b0);
    rd("early", CPOB_IDX_SUMMARY, 8'h0, 33'h0);
    repeat (4 * TICK) @(negedge clock);
    rd("lost", CPOB_IDX_SUMMARY, 8'h0, 33'h11);
    rd("logged", CPOB_IDX_HISTORY, 8'h1, {1'b0, 16'h0, CPOB_SYNC_ERR});
    sync_rx = 1'b1;
    @(negedge clock);
    sync_rx = 1'b0;
    rd("sync back", CPOB_IDX_SUMMARY, 8'h0, 33'h0);
    wr(CPOB_IDX_SYNC_PER, 8'h0, 32'h0, 1'b0);
  endtask
  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    t_reset();
    t_profile();
    t_summary();
    t_history();
    t_sync();
    report_and_stop();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule
